// >>> design/lane_cfg_consts.vh
// Constants for the serial link lane configuration register slice.
// Assumes AHB-Lite word access; byte address = page base + 4 * register index.
`ifndef LANE_CFG_CONSTS_VH
`define LANE_CFG_CONSTS_VH

// Page bases within the decoded address window
`define ANA_PAGE_BASE 12'h000
`define DIG_PAGE_BASE 12'h100
`define DEC_ADDR_W 12

// Register indices, analog page
`define IDX_LANE1_DEEMPH 8'h12
`define IDX_LANE0_DEEMPH 8'h13
`define IDX_LANE2_DEEMPH 8'h14
`define IDX_LANE3_DEEMPH 8'h15
`define IDX_PLL_FACTOR 8'h16
`define IDX_PLL_RESTART 8'h17
`define IDX_OVR_OUT 8'h1a
`define IDX_PIN_OVR_EN 8'h1b

// Register indices, digital page
`define IDX_LANE_SHARE 8'h16
`define IDX_CHA_MAP 8'h31
`define IDX_CHB_MAP 8'h32
`define IDX_STATUS 8'h3f

// Field positions
`define DEEMPH_MSB 7
`define DEEMPH_LSB 2
`define LANE_SHARE_BIT 4
`define SHARE_FIXED_BIT 7
`define PLL_FACTOR_MSB 1
`define PLL_FACTOR_LSB 0
`define PLL_RESTART_BIT 6
`define OVR_OUT_BIT 1
`define PIN_OVR_EN_BIT 3
`define MAP_S0_MSB 1
`define MAP_S0_LSB 0
`define MAP_S1_MSB 3
`define MAP_S1_LSB 2

// Reset values
`define RST_DEEMPH 6'h00
`define RST_MAP 8'h00
`define RST_PLL_FACTOR 2'h0
`define RST_BIT 1'b0

// Serializer PLL factor codes
`define PLL_20X 2'b00
`define PLL_40X 2'b10

// Decimation modes
`define DEC_NONE 2'b00
`define DEC_BY2 2'b01
`define DEC_BY4 2'b10

// Fixed lanes when no remapping applies
`define LANE_0 2'd0
`define LANE_1 2'd1
`define LANE_2 2'd2
`define LANE_3 2'd3

// Status bits
`define ST_PLL_UNUSED 0
`define ST_PLL_MISMATCH 1
`define ST_PIN_OVERRIDE 2
`define ST_OVR_FLAG 3
`define ST_BUF_DATA 4
`define ST_STAGE_FULL 5

`define HTRANS_ACTIVE_BIT 1
`define WORD_ZERO 32'h0000_0000

`endif

// >>> design/serial_link_lane_config_regs.v
// Lane configuration registers and lane mapping for a two-channel serial link.
// Assumes an AHB-Lite master on hclk; overrange flag and power-down pin are asynchronous.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lane_cfg_consts.vh"

// Summary of operation
// (RQ1) Lane share bit in decimate-by-4 puts both channels on one lane.
// (RQ2) Two eight-bit maps steer channel A and B streams to lanes, reset zero.
// (RQ3) Each lane has a six-bit de-emphasis code in bits 7 to 2.
// (RQ4) De-emphasis registers serve lanes 1, 0, 2, 3; low two bits reserved.
// (RQ5) PLL factor code 00 is 20X, 10 is 40X; must match link mode.
// (RQ6) Software pulses PLL restart bit 6 from 0 to 1 to 0 after power-up.
// (RQ7) Overrange output bit plus override enable drives overrange flag onto pin.
// (RQ8) Override enable bit 3 replaces the pin's power-down function.
// (RQ9) Software writes reserved bits as zero, lane share bit 7 as one.
module serial_link_lane_config_regs #(
	parameter SAMPLE_W = 16
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire [31:0] hrdata,
	output wire hresp,
	input wire [1:0] decim_mode,
	input wire link_needs_40x,
	input wire [2*SAMPLE_W-1:0] chan_a_data,
	input wire [2*SAMPLE_W-1:0] chan_b_data,
	input wire sample_valid,
	output wire sample_ready,
	output wire [4*SAMPLE_W-1:0] lane_data,
	output wire [3:0] lane_active,
	output wire lane_valid,
	input wire lane_ready,
	output wire [5:0] lane0_deemphasis_level,
	output wire [5:0] lane1_deemphasis_level,
	output wire [5:0] lane2_deemphasis_level,
	output wire [5:0] lane3_deemphasis_level,
	output wire [1:0] serdes_pll_factor,
	output wire serdes_pll_restart,
	input wire fast_overrange_flag,
	input wire powerdown_pin_in,
	output wire powerdown_pin_out,
	output wire powerdown_pin_oe,
	output wire powerdown_request
);
	localparam W = SAMPLE_W;
	localparam FW = 4 * W + 4;

	function addr_hit;
		input [`DEC_ADDR_W-1:0] addr;
		input [`DEC_ADDR_W-1:0] base;
		input [7:0] idx;
		begin
			addr_hit = (addr == base + {2'b00, idx, 2'b00});
		end
	endfunction

	function [4*SAMPLE_W-1:0] put_word;
		input [4*SAMPLE_W-1:0] bus;
		input [1:0] lane;
		input [SAMPLE_W-1:0] word;
		begin
			put_word = bus;
			put_word[lane*SAMPLE_W +: SAMPLE_W] = word;
		end
	endfunction

	// Bus slave state
	reg hreadyout_q;
	reg [31:0] hrdata_q;
	reg hresp_q;
	reg wr_pend_q;
	reg rd_pend_q;
	reg [`DEC_ADDR_W-1:0] addr_q;
	wire take;
	reg [31:0] rd_data;

	// Configuration registers
	reg [5:0] deemph0_q;
	reg [5:0] deemph1_q;
	reg [5:0] deemph2_q;
	reg [5:0] deemph3_q;
	reg [1:0] pll_factor_q;
	reg pll_restart_q;
	reg ovr_out_q;
	reg pin_ovr_en_q;
	reg lane_share_q;
	reg [7:0] cha_map_q;
	reg [7:0] chb_map_q;

	// Pin side
	reg ovr_meta_q;
	reg ovr_sync_q;
	reg pdn_meta_q;
	reg pdn_sync_q;
	reg pin_out_q;
	reg pin_oe_q;
	reg pdn_req_q;

	// Data path
	reg [2*SAMPLE_W-1:0] stage_a_q;
	reg [2*SAMPLE_W-1:0] stage_b_q;
	reg stage_full_q;
	reg phase_q;
	reg sample_ready_q;
	reg stage_full_d;
	reg [4*SAMPLE_W-1:0] frm_data;
	reg [3:0] frm_act;
	reg [1:0] lane_a0;
	reg [1:0] lane_a1;
	reg [1:0] lane_b0;
	reg [1:0] lane_b1;
	wire share_now;
	wire buf_in_ready;
	wire buf_push;
	wire pop_stage;
	wire pll_unused;
	wire pll_mismatch;

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;
	assign lane0_deemphasis_level = deemph0_q;
	assign lane1_deemphasis_level = deemph1_q;
	assign lane2_deemphasis_level = deemph2_q;
	assign lane3_deemphasis_level = deemph3_q;
	assign serdes_pll_factor = pll_factor_q;
	assign serdes_pll_restart = pll_restart_q;
	assign powerdown_pin_out = pin_out_q;
	assign powerdown_pin_oe = pin_oe_q;
	assign powerdown_request = pdn_req_q;
	assign sample_ready = sample_ready_q;

	// Address phase capture; reads take one wait state so a preceding write is seen
	assign take = hsel && htrans[`HTRANS_ACTIVE_BIT] && hready;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hrdata_q <= `WORD_ZERO;
			hresp_q <= 1'b0;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= {`DEC_ADDR_W{1'b0}};
		end else begin
			hresp_q <= 1'b0;
			wr_pend_q <= take && hwrite;
			rd_pend_q <= take && !hwrite;
			hreadyout_q <= !(take && !hwrite);
			if (take)
				addr_q <= haddr[`DEC_ADDR_W-1:0];
			if (rd_pend_q)
				hrdata_q <= rd_data;
		end
	end

	assign pll_unused = pll_factor_q[`PLL_FACTOR_LSB];
	assign pll_mismatch = pll_unused || ((pll_factor_q == `PLL_40X) != link_needs_40x); // RQ5

	// Read mux; reserved and write-only bits read zero
	always @* begin
		rd_data = `WORD_ZERO;
		if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_LANE1_DEEMPH))
			rd_data[`DEEMPH_MSB:`DEEMPH_LSB] = deemph1_q; // RQ4
		else if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_LANE0_DEEMPH))
			rd_data[`DEEMPH_MSB:`DEEMPH_LSB] = deemph0_q; // RQ4
		else if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_LANE2_DEEMPH))
			rd_data[`DEEMPH_MSB:`DEEMPH_LSB] = deemph2_q; // RQ4
		else if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_LANE3_DEEMPH))
			rd_data[`DEEMPH_MSB:`DEEMPH_LSB] = deemph3_q; // RQ4
		else if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_PLL_FACTOR))
			rd_data[`PLL_FACTOR_MSB:`PLL_FACTOR_LSB] = pll_factor_q;
		else if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_PLL_RESTART))
			rd_data[`PLL_RESTART_BIT] = pll_restart_q;
		else if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_OVR_OUT))
			rd_data[`OVR_OUT_BIT] = ovr_out_q;
		else if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_PIN_OVR_EN))
			rd_data[`PIN_OVR_EN_BIT] = pin_ovr_en_q;
		else if (addr_hit(addr_q, `DIG_PAGE_BASE, `IDX_LANE_SHARE)) begin
			rd_data[`SHARE_FIXED_BIT] = 1'b1;
			rd_data[`LANE_SHARE_BIT] = lane_share_q;
		end else if (addr_hit(addr_q, `DIG_PAGE_BASE, `IDX_CHA_MAP))
			rd_data[7:0] = cha_map_q;
		else if (addr_hit(addr_q, `DIG_PAGE_BASE, `IDX_CHB_MAP))
			rd_data[7:0] = chb_map_q;
		else if (addr_hit(addr_q, `DIG_PAGE_BASE, `IDX_STATUS)) begin
			rd_data[`ST_PLL_UNUSED] = pll_unused;
			rd_data[`ST_PLL_MISMATCH] = pll_mismatch;
			rd_data[`ST_PIN_OVERRIDE] = pin_ovr_en_q;
			rd_data[`ST_OVR_FLAG] = ovr_sync_q;
			rd_data[`ST_BUF_DATA] = lane_valid;
			rd_data[`ST_STAGE_FULL] = stage_full_q;
		end
	end

	// Register writes in the data phase; reserved bits are dropped
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deemph0_q <= `RST_DEEMPH;
			deemph1_q <= `RST_DEEMPH;
			deemph2_q <= `RST_DEEMPH;
			deemph3_q <= `RST_DEEMPH;
			pll_factor_q <= `RST_PLL_FACTOR;
			pll_restart_q <= `RST_BIT;
			ovr_out_q <= `RST_BIT;
			pin_ovr_en_q <= `RST_BIT;
			lane_share_q <= `RST_BIT;
			cha_map_q <= `RST_MAP;
			chb_map_q <= `RST_MAP;
		end else if (wr_pend_q) begin
			if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_LANE1_DEEMPH))
				deemph1_q <= hwdata[`DEEMPH_MSB:`DEEMPH_LSB]; // RQ3
			if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_LANE0_DEEMPH))
				deemph0_q <= hwdata[`DEEMPH_MSB:`DEEMPH_LSB]; // RQ3
			if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_LANE2_DEEMPH))
				deemph2_q <= hwdata[`DEEMPH_MSB:`DEEMPH_LSB]; // RQ3
			if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_LANE3_DEEMPH))
				deemph3_q <= hwdata[`DEEMPH_MSB:`DEEMPH_LSB]; // RQ3
			if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_PLL_FACTOR))
				pll_factor_q <= hwdata[`PLL_FACTOR_MSB:`PLL_FACTOR_LSB]; // RQ5
			if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_PLL_RESTART))
				pll_restart_q <= hwdata[`PLL_RESTART_BIT]; // RQ6
			if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_OVR_OUT))
				ovr_out_q <= hwdata[`OVR_OUT_BIT];
			if (addr_hit(addr_q, `ANA_PAGE_BASE, `IDX_PIN_OVR_EN))
				pin_ovr_en_q <= hwdata[`PIN_OVR_EN_BIT];
			if (addr_hit(addr_q, `DIG_PAGE_BASE, `IDX_LANE_SHARE))
				lane_share_q <= hwdata[`LANE_SHARE_BIT];
			if (addr_hit(addr_q, `DIG_PAGE_BASE, `IDX_CHA_MAP))
				cha_map_q <= hwdata[7:0]; // RQ2
			if (addr_hit(addr_q, `DIG_PAGE_BASE, `IDX_CHB_MAP))
				chb_map_q <= hwdata[7:0]; // RQ2
		end
	end

	// Power-down pin: synchronise inputs, then override when enabled
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovr_meta_q <= 1'b0;
			ovr_sync_q <= 1'b0;
			pdn_meta_q <= 1'b0;
			pdn_sync_q <= 1'b0;
			pin_out_q <= 1'b0;
			pin_oe_q <= 1'b0;
			pdn_req_q <= 1'b0;
		end else begin
			ovr_meta_q <= fast_overrange_flag;
			ovr_sync_q <= ovr_meta_q;
			pdn_meta_q <= powerdown_pin_in;
			pdn_sync_q <= pdn_meta_q;
			pin_oe_q <= pin_ovr_en_q && ovr_out_q; // RQ7
			pin_out_q <= pin_ovr_en_q && ovr_out_q && ovr_sync_q; // RQ7
			pdn_req_q <= !pin_ovr_en_q && pdn_sync_q; // RQ8
		end
	end

	// Lane assignment per stream
	assign share_now = lane_share_q && (decim_mode == `DEC_BY4); // RQ1

	always @* begin
		lane_a0 = `LANE_0;
		lane_a1 = `LANE_1;
		lane_b0 = `LANE_2;
		lane_b1 = `LANE_3;
		if (decim_mode == `DEC_BY2 || decim_mode == `DEC_BY4) begin
			lane_a0 = cha_map_q[`MAP_S0_MSB:`MAP_S0_LSB]; // RQ2
			lane_a1 = cha_map_q[`MAP_S1_MSB:`MAP_S1_LSB]; // RQ2
			lane_b0 = chb_map_q[`MAP_S0_MSB:`MAP_S0_LSB]; // RQ2
			lane_b1 = chb_map_q[`MAP_S1_MSB:`MAP_S1_LSB]; // RQ2
		end
	end

	// Frame build; later streams win on a lane collision
	always @* begin
		frm_data = {4*W{1'b0}};
		frm_act = 4'h0;
		if (share_now) begin
			frm_data = put_word(frm_data, lane_a0, phase_q ? stage_b_q[W-1:0] : stage_a_q[W-1:0]); // RQ1
			frm_act[lane_a0] = 1'b1; // RQ1
		end else if (decim_mode == `DEC_BY4) begin
			frm_data = put_word(frm_data, lane_a0, stage_a_q[W-1:0]);
			frm_data = put_word(frm_data, lane_b0, stage_b_q[W-1:0]);
			frm_act[lane_a0] = 1'b1;
			frm_act[lane_b0] = 1'b1;
		end else begin
			frm_data = put_word(frm_data, lane_a0, stage_a_q[W-1:0]);
			frm_data = put_word(frm_data, lane_a1, stage_a_q[2*W-1:W]);
			frm_data = put_word(frm_data, lane_b0, stage_b_q[W-1:0]);
			frm_data = put_word(frm_data, lane_b1, stage_b_q[2*W-1:W]);
			frm_act[lane_a0] = 1'b1;
			frm_act[lane_a1] = 1'b1;
			frm_act[lane_b0] = 1'b1;
			frm_act[lane_b1] = 1'b1;
		end
	end

	// Shared lane takes two beats per sample pair
	assign buf_push = stage_full_q && buf_in_ready;
	assign pop_stage = buf_push && !(share_now && !phase_q);

	always @* begin
		stage_full_d = (stage_full_q && !pop_stage) || (sample_valid && sample_ready_q);
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage_a_q <= {2*W{1'b0}};
			stage_b_q <= {2*W{1'b0}};
			stage_full_q <= 1'b0;
			phase_q <= 1'b0;
			sample_ready_q <= 1'b0;
		end else begin
			if (sample_valid && sample_ready_q) begin
				stage_a_q <= chan_a_data;
				stage_b_q <= chan_b_data;
			end
			if (buf_push)
				phase_q <= !pop_stage;
			stage_full_q <= stage_full_d;
			sample_ready_q <= !stage_full_d;
		end
	end

	two_entry_buffer #(
		.WIDTH(FW)
	) u_lane_buf (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_data({frm_act, frm_data}),
		.in_valid(stage_full_q),
		.in_ready(buf_in_ready),
		.out_data({lane_active, lane_data}),
		.out_valid(lane_valid),
		.out_ready(lane_ready)
	);
endmodule // serial_link_lane_config_regs

`default_nettype wire

// >>> design/two_entry_buffer.v
// Two-entry valid/ready buffer; head entry and all flags are flip-flops.
// Assumes one clock; the drain side may stall at any time.
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
	parameter WIDTH = 68
) (
	input wire hclk,
	input wire hresetn,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] slot0_q;
	reg [WIDTH-1:0] slot1_q;
	reg v0_q;
	reg v1_q;
	reg rdy_q;
	reg [WIDTH-1:0] slot0_d;
	reg [WIDTH-1:0] slot1_d;
	reg v0_d;
	reg v1_d;
	wire push;
	wire pop;

	assign push = in_valid && rdy_q;
	assign pop = v0_q && out_ready;
	assign in_ready = rdy_q;
	assign out_valid = v0_q;
	assign out_data = slot0_q;

	always @* begin
		slot0_d = slot0_q;
		slot1_d = slot1_q;
		v0_d = v0_q;
		v1_d = v1_q;
		case ({push, pop})
			2'b10: begin
				if (!v0_q) begin
					slot0_d = in_data;
					v0_d = 1'b1;
				end else begin
					slot1_d = in_data;
					v1_d = 1'b1;
				end
			end
			2'b01: begin
				slot0_d = slot1_q;
				v0_d = v1_q;
				v1_d = 1'b0;
			end
			2'b11: begin
				if (v1_q) begin
					slot0_d = slot1_q;
					slot1_d = in_data;
				end else begin
					slot0_d = in_data;
				end
			end
			default: begin
				v0_d = v0_q;
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slot0_q <= {WIDTH{1'b0}};
			slot1_q <= {WIDTH{1'b0}};
			v0_q <= 1'b0;
			v1_q <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			slot0_q <= slot0_d;
			slot1_q <= slot1_d;
			v0_q <= v0_d;
			v1_q <= v1_d;
			rdy_q <= !v1_d;
		end
	end
endmodule // two_entry_buffer

`default_nettype wire

// >>> dv/lane_cfg_checker_properties.sv
// Bus, stream and pin properties of the lane configuration registers.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module lane_cfg_checker #(
	parameter SAMPLE_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic sample_valid,
	input wire logic sample_ready,
	input wire logic [4*SAMPLE_W-1:0] lane_data,
	input wire logic [3:0] lane_active,
	input wire logic lane_valid,
	input wire logic lane_ready,
	input wire logic [5:0] lane0_deemphasis_level,
	input wire logic [5:0] lane1_deemphasis_level,
	input wire logic [1:0] serdes_pll_factor,
	input wire logic serdes_pll_restart,
	input wire logic powerdown_pin_out,
	input wire logic powerdown_pin_oe
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic acc;
	wire logic wr;
	assign acc = hsel && htrans[1] && hready;
	assign wr = acc && hwrite;
	a_resp_okay: assert property (!hresp) else $error("hresp not OKAY");
	a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (wr |=> hreadyout) else $error("write stalled");
	a_lane1_order: assert property (wr && haddr[11:0] == 12'h048 ##1 1'b1 |=>
		lane1_deemphasis_level == $past(hwdata[7:2])) else $error("lane1 level wrong");
	a_lane0_order: assert property (wr && haddr[11:0] == 12'h04c ##1 1'b1 |=>
		lane0_deemphasis_level == $past(hwdata[7:2])) else $error("lane0 level wrong");
	a_pll_code: assert property (wr && haddr[11:0] == 12'h058 ##1 1'b1 |=>
		serdes_pll_factor == $past(hwdata[1:0])) else $error("pll factor wrong");
	a_restart_level: assert property (wr && haddr[11:0] == 12'h05c ##1 1'b1 |=>
		serdes_pll_restart == $past(hwdata[6])) else $error("restart level wrong");
	a_lane_hold: assert property (lane_valid && !lane_ready |=>
		lane_valid && $stable(lane_data) && $stable(lane_active)) else $error("lane beat dropped");
	a_take_gap: assert property (sample_valid && sample_ready |=> !sample_ready)
		else $error("sample taken twice in a row");
	a_pin_drive: assert property (powerdown_pin_out |-> powerdown_pin_oe)
		else $error("pin out without enable");
endmodule // lane_cfg_checker
bind serial_link_lane_config_regs lane_cfg_checker #(.SAMPLE_W(SAMPLE_W)) chk (.hclk, .hresetn,
	.hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .sample_valid,
	.sample_ready, .lane_data, .lane_active, .lane_valid, .lane_ready, .lane0_deemphasis_level,
	.lane1_deemphasis_level, .serdes_pll_factor, .serdes_pll_restart, .powerdown_pin_out,
	.powerdown_pin_oe);
`default_nettype wire

// >>> dv/lane_sink.sv
// Far-side lane receiver model: takes lane beats, with a random or held ready.
// Assumes the bench seeds the generator; hold forces a long stall.
`timescale 1ns/1ps
`default_nettype none
module lane_sink (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hold,
	output var logic lane_ready
);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			lane_ready <= 1'b0;
		else
			lane_ready <= !hold && ($urandom_range(3) != 0);
	end
endmodule // lane_sink
`default_nettype wire

// >>> dv/serial_link_lane_config_regs_tb_top.sv
// Self-checking bench for the lane configuration registers.
// Assumes AHB-Lite single word transfers and the lane sink model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, y) begin n_compared++; if ((x) !== (y)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, x, y); end end
module serial_link_lane_config_regs_tb_top;
	typedef struct packed {logic [3:0] act; logic [63:0] dat;} exp_t;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hold = 0, sample_valid = 0;
	logic link_needs_40x = 0, fast_overrange_flag = 0, powerdown_pin_in = 0;
	logic [31:0] haddr = 0, hwdata = 0, chan_a_data = 0, chan_b_data = 0, a, b, r;
	logic [1:0] htrans = 0, decim_mode = 0;
	logic [2:0] hsize = 0;
	wire logic hreadyout, hresp, sample_ready, lane_valid, lane_ready, serdes_pll_restart;
	wire logic powerdown_pin_out, powerdown_pin_oe, powerdown_request;
	wire logic [31:0] hrdata;
	wire logic [63:0] lane_data;
	wire logic [3:0] lane_active;
	wire logic [5:0] dl0, dl1, dl2, dl3;
	wire logic [1:0] serdes_pll_factor;
	int n_fail = 0, n_compared = 0, k, acc;
	exp_t eq[$];
	exp_t e;
	logic [5:0] codes [7] = '{0, 1, 3, 7, 15, 31, 63};
	logic [11:0] ra [11] = '{12'h048, 12'h04c, 12'h050, 12'h054, 12'h058, 12'h05c, 12'h068,
		12'h06c, 12'h158, 12'h1c4, 12'h1c8};
	serial_link_lane_config_regs #(.SAMPLE_W(16)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .decim_mode,
		.link_needs_40x, .chan_a_data, .chan_b_data, .sample_valid, .sample_ready, .lane_data,
		.lane_active, .lane_valid, .lane_ready, .lane0_deemphasis_level(dl0),
		.lane1_deemphasis_level(dl1), .lane2_deemphasis_level(dl2), .lane3_deemphasis_level(dl3),
		.serdes_pll_factor, .serdes_pll_restart, .fast_overrange_flag, .powerdown_pin_in,
		.powerdown_pin_out, .powerdown_pin_oe, .powerdown_request);
	lane_sink sink (.hclk, .hresetn, .hold, .lane_ready);
	initial forever #10 hclk = ~hclk;
	task automatic ahb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		haddr <= {20'h0_0000, ad};
		hwrite <= w;
		htrans <= 2'b10;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0000_0000;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		hsel <= 0;
	endtask
	task automatic rdc(input logic [11:0] ad, input logic [31:0] x);
		ahb(0, ad, 0);
		`CHK(r, x)
	endtask
	task automatic note(input logic [3:0] t, input logic [63:0] d);
		eq.push_back('{t, d});
	endtask
	task automatic send(input int lim);
		@(posedge hclk);
		chan_a_data <= a;
		chan_b_data <= b;
		sample_valid <= 1;
		k = 0;
		do begin @(posedge hclk); k++; end while (sample_ready !== 1'b1 && k < lim);
		sample_valid <= 0;
	endtask
	task automatic drain;
		k = 0;
		while (eq.size() != 0 && k < 500) begin @(posedge hclk); k++; end
		`CHK(eq.size(), 0)
	endtask
	task automatic test_done;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge hclk) begin
		if (hresetn && lane_valid === 1'b1 && lane_ready === 1'b1) begin
			`CHK(eq.size() > 0, 1'b1)
			if (eq.size() > 0) begin
				e = eq.pop_front();
				`CHK(lane_active, e.act)
				for (int i = 0; i < 4; i++)
					if (e.act[i]) `CHK(lane_data[16*i+:16], e.dat[16*i+:16])
			end
		end
	end
	initial begin
		#1_000_000;
		n_fail++;
		test_done;
	end
	initial begin
		void'($urandom(32'h0000_2ebf));
		repeat (12) @(posedge hclk);
		hresetn <= 1;
		foreach (ra[i]) rdc(ra[i], i == 8 ? 32'h0000_0080 : 0);
		ahb(1, 12'h0f0, 32'hffff_ffff);
		rdc(12'h0f0, 0);
		$display("reset and unmapped test done");
		for (int i = 0; i < 7; i++) begin
			for (int j = 0; j < 4; j++) ahb(1, 12'(12'h048 + 4 * j), 32'({codes[(i + j) % 7], 2'b00}));
			@(posedge hclk);
			`CHK({dl3, dl2, dl0, dl1}, {codes[(i+3)%7], codes[(i+2)%7], codes[(i+1)%7], codes[i]})
			rdc(12'h04c, 32'({codes[(i + 1) % 7], 2'b00}));
		end
		$display("de-emphasis test done");
		link_needs_40x <= 1;
		for (int c = 0; c < 4; c++) begin
			ahb(1, 12'h058, 32'(c));
			ahb(0, 12'h1fc, 0);
			`CHK(serdes_pll_factor, 2'(c))
			`CHK(r[1:0], c == 2 ? 2'b00 : (c == 0 ? 2'b10 : 2'b11))
		end
		link_needs_40x <= 0;
		ahb(1, 12'h058, 32'h0000_0002);
		ahb(0, 12'h1fc, 0);
		`CHK(r[1:0], 2'b10)
		ahb(1, 12'h05c, 32'h0000_0040);
		@(posedge hclk);
		`CHK(serdes_pll_restart, 1'b1)
		ahb(1, 12'h05c, 0);
		@(posedge hclk);
		`CHK(serdes_pll_restart, 1'b0)
		$display("pll test done");
		fast_overrange_flag <= 1;
		powerdown_pin_in <= 1;
		ahb(1, 12'h06c, 32'h0000_0008);
		repeat (6) @(posedge hclk);
		`CHK({powerdown_pin_oe, powerdown_request}, 2'b00)
		ahb(1, 12'h068, 32'h0000_0002);
		repeat (6) @(posedge hclk);
		`CHK({powerdown_pin_oe, powerdown_pin_out}, 2'b11)
		ahb(0, 12'h1fc, 0);
		`CHK(r[3:2], 2'b11)
		fast_overrange_flag <= 0;
		repeat (6) @(posedge hclk);
		`CHK(powerdown_pin_out, 1'b0)
		ahb(1, 12'h06c, 0);
		repeat (6) @(posedge hclk);
		`CHK({powerdown_pin_oe, powerdown_request}, 2'b01)
		$display("pin test done");
		for (int c = 0; c < 4; c++) begin
			ahb(1, 12'h1c4, c == 1 ? 32'h0000_000e : 0);
			ahb(1, 12'h1c8, c == 1 ? 32'h0000_0004 : (c == 2 ? 32'h0000_0001 : 0));
			ahb(1, 12'h158, c == 3 ? 32'h0000_0090 : 32'h0000_0080);
			decim_mode <= c == 0 ? 2'b00 : (c == 1 ? 2'b01 : 2'b10);
			repeat (6) begin
				a = $urandom;
				b = $urandom;
				case (c)
					0: note(4'hf, {b, a});
					1: note(4'hf, {a, b});
					2: note(4'h3, {32'h0000_0000, b[15:0], a[15:0]});
					default: begin
						note(4'h1, {48'h0000_0000_0000, a[15:0]});
						note(4'h1, {48'h0000_0000_0000, b[15:0]});
					end
				endcase
				send(200);
			end
			drain;
		end
		$display("lane mapping test done");
		decim_mode <= 2'b00;
		hold <= 1;
		acc = 0;
		for (int i = 0; i < 5; i++) begin
			a = $urandom;
			b = $urandom;
			note(4'hf, {b, a});
			send(20);
			if (sample_ready === 1'b1) acc++;
			else void'(eq.pop_back());
		end
		`CHK(acc, 3)
		hold <= 0;
		drain;
		$display("buffer stall test done");
		hresetn <= 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		foreach (ra[i]) rdc(ra[i], i == 8 ? 32'h0000_0080 : 0);
		$display("mid-run reset test done");
		test_done;
	end
endmodule // serial_link_lane_config_regs_tb_top
`default_nettype wire
